// File: uart_irq_fifo_cfg.svh
// register offsets, field positions, reset values and timing counts of the channel control block
`ifndef UART_IRQ_FIFO_CFG_SVH
`define UART_IRQ_FIFO_CFG_SVH

// register offsets on the host register port
`define ADDR_INTERRUPT_ENABLE  4'h1
`define ADDR_FIFO_CONTROL      4'h2
`define ADDR_INTERRUPT_IDENT   4'h2

// interrupt enable bit positions
`define IEN_CTS_BIT            7
`define IEN_RTS_BIT            6
`define IEN_XOFF_BIT           5
`define IEN_SLEEP_BIT          4
`define IEN_MODEM_BIT          3
`define IEN_LINE_BIT           2
`define IEN_TX_BIT             1
`define IEN_RX_BIT             0
`define IEN_ENH_HI             7
`define IEN_ENH_LO             4

// fifo control field positions
`define FCTL_RX_TRIG_HI        7
`define FCTL_RX_TRIG_LO        6
`define FCTL_TX_TRIG_HI        5
`define FCTL_TX_TRIG_LO        4
`define FCTL_TX_RESET_BIT      2
`define FCTL_RX_RESET_BIT      1
`define FCTL_ENABLE_BIT        0

// reset values
`define INTERRUPT_ENABLE_RST   8'h00
`define TRIG_SEL_RST           2'h0

// trigger levels, in characters (rx) or free spaces (tx)
`define RX_TRIG_LVL_00         7'h08
`define RX_TRIG_LVL_01         7'h10
`define RX_TRIG_LVL_10         7'h38
`define RX_TRIG_LVL_11         7'h3C
`define TX_TRIG_LVL_00         7'h08
`define TX_TRIG_LVL_01         7'h10
`define TX_TRIG_LVL_10         7'h20
`define TX_TRIG_LVL_11         7'h38

// fifo clear length, in crystal clock periods
`define FIFO_RST_CLOCKS        2
`define FIFO_RST_CYCLES        (`FIFO_RST_CLOCKS)

`endif

// File: uart_irq_fifo_pkg.sv
// types shared by the channel control block and its fifo clear timer
package uart_irq_fifo_pkg;

	typedef enum logic [0:0] {
		TMR_IDLE  = 1'b0,
		TMR_CLEAR = 1'b1
	} tmr_state_t;

	typedef struct packed {
		tmr_state_t state;
		logic [1:0] count;
		logic       clr;
	} tmr_regs_t;

	typedef struct packed {
		logic [7:0] interrupt_enable_reg;
		logic       fifo_en;
		logic [1:0] rx_trig_sel;
		logic [1:0] tx_trig_sel;
		logic       tx_pend;
		logic       tx_below_d;
		logic       irq_n;
		logic [7:0] rdata;
		logic [6:0] rx_lvl;
		logic [6:0] tx_lvl;
	} ctl_regs_t;

endpackage

// File: fifo_clr_if.sv
// request and clear strobe between the control block and a fifo clear timer
`timescale 1ns/1ps
interface fifo_clr_if;
	logic start;
	logic clr;

	modport ctrl (output start, input clr);
	modport timer (input start, output clr);
endinterface

// File: fifo_clear_timer.sv
// stretches a fifo reset request into a clear strobe of fixed length
`timescale 1ns/1ps
`include "uart_irq_fifo_cfg.svh"
module fifo_clear_timer
	import uart_irq_fifo_pkg::*;
(
	input  wire logic  i_sys_clk,
	input  wire logic  i_rst,
	fifo_clr_if.timer  clr_port
);

	tmr_regs_t st;
	tmr_regs_t next_st;

	localparam logic [1:0] LAST_COUNT = 2'(`FIFO_RST_CYCLES - 1);

	assign clr_port.clr = st.clr;

	// a new request restarts the count so a clear never ends early
	always_comb begin
		next_st = st;
		unique case (st.state)
			TMR_IDLE: begin
				if (clr_port.start) begin
					next_st.state = TMR_CLEAR;
					next_st.count = LAST_COUNT; // R18
					next_st.clr   = 1'b1;
				end
			end
			TMR_CLEAR: begin
				if (clr_port.start) begin
					next_st.count = LAST_COUNT;
				end else if (st.count == 2'h0) begin
					next_st.state = TMR_IDLE; // R15 R16
					next_st.clr   = 1'b0;
				end else begin
					next_st.count = st.count - 2'h1;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{state: TMR_IDLE, count: 2'h0, clr: 1'b0};
		end else begin
			st <= next_st;
		end
	end

endmodule

// File: uart_irq_enable_fifo_ctrl.sv
// interrupt enable and fifo control registers of one uart channel
// Notes on behaviour
// R1: enabled pending source drives interrupt low
// R2: bits 7,6 enable cts/rts interrupts, reset clear
// R3: bit 5 enables xoff interrupt, reset clear
// R4: bit 4 selects sleep, reset clear
// R5: bit 3 enables modem interrupt, reset clear
// R6: bit 2 enables line status interrupt
// R7: bit 1 enables transmit fifo interrupt
// R8: bit 0 enables receive data interrupt
// R9: bits 7..4 writable only with enhanced bit
// R10: re-enabling transmit interrupt raises nothing new
// R11: fifo control register is write-only
// R12: rx trigger 8, 16, 56, 60 characters
// R13: tx trigger 8, 16, 32, 56 spaces
// R14: tx trigger changes only with enhanced bit
// R15: tx fifo reset bit clears, self-clears
// R16: rx fifo reset bit clears, self-clears
// R17: bit 0 enables both fifos, reset clear
// R18: fifo reset lasts two crystal clocks
// R19: host waits two clocks after fifo reset
// R20: ident bits 7:6 mirror fifo enable
// R21: interrupt released when nothing enabled pending
`timescale 1ns/1ps
`include "uart_irq_fifo_cfg.svh"
module uart_irq_enable_fifo_ctrl
	import uart_irq_fifo_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_enhanced_en,
	input  wire logic [7:0] i_int_src,
	input  wire logic       i_tx_int_clr,
	output logic [7:0]      o_rdata,
	output logic            o_irq_n,
	output logic            o_sleep_en,
	output logic            o_fifo_en,
	output logic [1:0]      o_ident_fifo_bits,
	output logic [6:0]      o_rx_trig_lvl,
	output logic [6:0]      o_tx_trig_lvl,
	output logic            o_tx_fifo_clr,
	output logic            o_rx_fifo_clr
);

	ctl_regs_t st;
	ctl_regs_t next_st;

	fifo_clr_if tx_clr ();
	fifo_clr_if rx_clr ();

	// receive trigger code to character count
	function automatic logic [6:0] rx_trig_decode(input logic [1:0] sel);
		logic [6:0] lvl;
		lvl = `RX_TRIG_LVL_00;
		unique case (sel)
			2'h0: lvl = `RX_TRIG_LVL_00; // R12
			2'h1: lvl = `RX_TRIG_LVL_01;
			2'h2: lvl = `RX_TRIG_LVL_10;
			2'h3: lvl = `RX_TRIG_LVL_11;
		endcase
		return lvl;
	endfunction

	// transmit trigger code to free-space count
	function automatic logic [6:0] tx_trig_decode(input logic [1:0] sel);
		logic [6:0] lvl;
		lvl = `TX_TRIG_LVL_00;
		unique case (sel)
			2'h0: lvl = `TX_TRIG_LVL_00; // R13
			2'h1: lvl = `TX_TRIG_LVL_01;
			2'h2: lvl = `TX_TRIG_LVL_10;
			2'h3: lvl = `TX_TRIG_LVL_11;
		endcase
		return lvl;
	endfunction

	logic wr_ien;
	logic wr_fctl;
	logic tx_rise;

	// write decode; fifo control shares its offset with the read-only ident
	assign wr_ien  = i_wr_en && (i_addr == `ADDR_INTERRUPT_ENABLE);
	assign wr_fctl = i_wr_en && (i_addr == `ADDR_FIFO_CONTROL);
	assign tx_rise = i_int_src[`IEN_TX_BIT] && !st.tx_below_d;

	// reset bits are never stored, they only fire the timers
	assign tx_clr.start = wr_fctl && i_wdata[`FCTL_TX_RESET_BIT]; // R15
	assign rx_clr.start = wr_fctl && i_wdata[`FCTL_RX_RESET_BIT]; // R16

	fifo_clear_timer u_tx_clear (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.clr_port  (tx_clr.timer)
	);

	fifo_clear_timer u_rx_clear (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.clr_port  (rx_clr.timer)
	);

	// outputs straight from flops
	assign o_rdata           = st.rdata;
	assign o_irq_n           = st.irq_n;
	assign o_sleep_en        = st.interrupt_enable_reg[`IEN_SLEEP_BIT]; // R4
	assign o_fifo_en         = st.fifo_en;
	assign o_ident_fifo_bits = {st.fifo_en, st.fifo_en}; // R20
	assign o_rx_trig_lvl     = st.rx_lvl;
	assign o_tx_trig_lvl     = st.tx_lvl;
	assign o_tx_fifo_clr     = tx_clr.clr;
	assign o_rx_fifo_clr     = rx_clr.clr;

	// next-state logic for the whole register bank
	always_comb begin
		logic [7:0] ien_new;
		logic [7:0] src;
		logic       pending;
		ien_new = st.interrupt_enable_reg;
		src     = 8'h00;
		pending = 1'b0;
		next_st = st;
		next_st.tx_below_d = i_int_src[`IEN_TX_BIT];

		// enable register write; upper nibble guarded by the enhanced bit
		if (wr_ien) begin
			ien_new[`IEN_ENH_LO-1:0] = i_wdata[`IEN_ENH_LO-1:0]; // R5 R6 R7 R8
			if (i_enhanced_en) begin
				ien_new[`IEN_ENH_HI:`IEN_ENH_LO] = i_wdata[`IEN_ENH_HI:`IEN_ENH_LO]; // R9 R2 R3
			end
			next_st.interrupt_enable_reg = ien_new;
		end

		// transmit interrupt is an event: latched on the threshold crossing only
		if (i_tx_int_clr) begin
			next_st.tx_pend = 1'b0;
		end
		if (wr_ien && ien_new[`IEN_TX_BIT] && !st.interrupt_enable_reg[`IEN_TX_BIT]) begin
			next_st.tx_pend = 1'b0; // R10
		end
		if (tx_rise) begin
			next_st.tx_pend = 1'b1; // set wins over any clear
		end

		// fifo control write; the register has no read path
		if (wr_fctl) begin
			next_st.fifo_en     = i_wdata[`FCTL_ENABLE_BIT]; // R17
			next_st.rx_trig_sel = i_wdata[`FCTL_RX_TRIG_HI:`FCTL_RX_TRIG_LO]; // R12
			if (i_enhanced_en) begin
				next_st.tx_trig_sel = i_wdata[`FCTL_TX_TRIG_HI:`FCTL_TX_TRIG_LO]; // R14
			end
		end

		// trigger levels; tx field only counts while enhanced mode is on
		next_st.rx_lvl = rx_trig_decode(next_st.rx_trig_sel);
		next_st.tx_lvl = i_enhanced_en ? tx_trig_decode(next_st.tx_trig_sel)
			: tx_trig_decode(`TRIG_SEL_RST); // R14

		// gate sources by their enables; sleep bit is no source
		src = i_int_src;
		src[`IEN_SLEEP_BIT] = 1'b0;
		src[`IEN_TX_BIT]    = st.tx_pend;
		pending = |(src & st.interrupt_enable_reg);
		next_st.irq_n = !pending; // R1 R21

		// read mux; the fifo control offset reads back the ident byte
		if (i_rd_en) begin
			unique case (i_addr)
				`ADDR_INTERRUPT_ENABLE: next_st.rdata = st.interrupt_enable_reg;
				`ADDR_INTERRUPT_IDENT:  next_st.rdata = {st.fifo_en, st.fifo_en,
					5'h00, st.irq_n}; // R11 R20
				default:                next_st.rdata = 8'h00;
			endcase
		end
	end

	// register bank
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{interrupt_enable_reg: `INTERRUPT_ENABLE_RST,
				fifo_en: 1'b0,
				rx_trig_sel: `TRIG_SEL_RST,
				tx_trig_sel: `TRIG_SEL_RST,
				tx_pend: 1'b0,
				tx_below_d: 1'b0,
				irq_n: 1'b1,
				rdata: 8'h00,
				rx_lvl: `RX_TRIG_LVL_00,
				tx_lvl: `TX_TRIG_LVL_00};
		end else begin
			st <= next_st;
		end
	end

endmodule

// File: uart_irq_enable_fifo_ctrl_monitor.sv
// assertion checker for the uart channel control block
`timescale 1ns/1ps
module uart_irq_enable_fifo_ctrl_monitor (
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	input wire logic       i_wr_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_enhanced_en,
	input wire logic [7:0] i_int_src,
	input wire logic       o_irq_n,
	input wire logic       o_fifo_en,
	input wire logic [1:0] o_ident_fifo_bits,
	input wire logic [6:0] o_rx_trig_lvl,
	input wire logic [6:0] o_tx_trig_lvl,
	input wire logic       o_tx_fifo_clr,
	input wire logic       o_rx_fifo_clr
);
	logic [7:0] interrupt_enable;
	logic [7:0] wd;
	logic       w2;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	function automatic logic [6:0] rx_lvl(input logic [1:0] s);
		return s[1] ? (s[0] ? 7'h3C : 7'h38) : (s[0] ? 7'h10 : 7'h08);
	endfunction
	function automatic logic [6:0] tx_lvl(input logic [1:0] s);
		return s[1] ? (s[0] ? 7'h38 : 7'h20) : (s[0] ? 7'h10 : 7'h08);
	endfunction

	// enable shadow; upper nibble locked outside enhanced mode
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			interrupt_enable <= 8'h00;
		else if (i_wr_en && i_addr == 4'h1)
			interrupt_enable <= i_enhanced_en ? i_wdata : {interrupt_enable[7:4], i_wdata[3:0]};
	end

	// last cycle's fifo control write, for the level checks
	always_ff @(posedge i_sys_clk) begin
		w2 <= i_wr_en && i_addr == 4'h2;
		wd <= i_wdata;
	end

	sequence tx_req;
		i_wr_en && i_addr == 4'h2 && i_wdata[2];
	endsequence
	sequence rx_req;
		i_wr_en && i_addr == 4'h2 && i_wdata[1];
	endsequence
	property tx_lvl_p;
		w2 && $past(i_enhanced_en) |-> o_tx_trig_lvl == tx_lvl(wd[5:4]);
	endproperty

	chk_tx_clr_len: assert property (tx_req |=> o_tx_fifo_clr [*2])
		else $error("tx clear strobe short");
	chk_rx_clr_len: assert property (rx_req |=> o_rx_fifo_clr [*2])
		else $error("rx clear strobe short");
	chk_ident_mirror: assert property (o_ident_fifo_bits == {2{o_fifo_en}})
		else $error("ident bits differ from fifo enable");
	chk_rx_lvl_map: assert property (w2 |-> o_rx_trig_lvl == rx_lvl(wd[7:6]))
		else $error("rx trigger level wrong");
	chk_tx_lvl_enh: assert property (tx_lvl_p)
		else $error("tx trigger level wrong");
	chk_tx_lvl_base: assert property (!$past(i_enhanced_en) |-> o_tx_trig_lvl == 7'h08)
		else $error("tx trigger level not base");
	chk_irq_raise: assert property (|(i_int_src & interrupt_enable & 8'hED) |=> !o_irq_n)
		else $error("irq not raised");
	chk_irq_release: assert property (interrupt_enable == 8'h00 |=> o_irq_n)
		else $error("irq not released");
endmodule

bind uart_irq_enable_fifo_ctrl uart_irq_enable_fifo_ctrl_monitor u_mon (.*);

// File: tb_uart_irq_enable_fifo_ctrl.sv
// self-checking bench for the uart channel control block
`timescale 1ns/1ps
module tb_uart_irq_enable_fifo_ctrl;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, enh = 0, txc = 0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wd = 8'h00, src = 8'h00, rdat, ier_m = 8'h00;
	logic        irq_n, slp, fen, txclr, rxclr;
	logic [1:0]  idb;
	logic [6:0]  rxl, txl;
	logic [31:0] lf = 32'h3AD2;
	logic [1:0]  txs_m = 2'h0;
	int          err_total = 0, cmp_count = 0;

	// 40 MHz
	always #12.5 clk = ~clk;

	uart_irq_enable_fifo_ctrl u_dut (.i_sys_clk(clk), .i_rst(rst), .i_wr_en(wr), .i_rd_en(rd),
		.i_addr(addr), .i_wdata(wd), .i_enhanced_en(enh), .i_int_src(src), .i_tx_int_clr(txc),
		.o_rdata(rdat), .o_irq_n(irq_n), .o_sleep_en(slp), .o_fifo_en(fen),
		.o_ident_fifo_bits(idb), .o_rx_trig_lvl(rxl), .o_tx_trig_lvl(txl),
		.o_tx_fifo_clr(txclr), .o_rx_fifo_clr(rxclr));

	// expected trigger levels from the documented code tables
	function automatic logic [6:0] rx_exp(input logic [1:0] s);
		return s[1] ? (s[0] ? 7'h3C : 7'h38) : (s[0] ? 7'h10 : 7'h08);
	endfunction

	function automatic logic [6:0] tx_exp(input logic [1:0] s);
		return s[1] ? (s[0] ? 7'h38 : 7'h20) : (s[0] ? 7'h10 : 7'h08);
	endfunction

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one-cycle write; model tracks the enable register lock
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		// model after the edge, once the caller's enhanced bit has settled
		if (a == 4'h1)
			ier_m = enh ? d : {ier_m[7:4], d[3:0]};
		if (a == 4'h2 && enh)
			txs_m = d[5:4];
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask

	// read data settles one edge after the strobe edge
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		@(posedge clk);
		@(negedge clk);
		chk(rdat, exp, nm);
	endtask

	task automatic step(input logic [7:0] s, input logic e, input string nm);
		@(posedge clk);
		src <= s;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(8'(irq_n), 8'(e), nm);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		logic [7:0] m;
		repeat (4) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk({1'b0, irq_n, slp, fen, idb, txclr, rxclr}, 8'h40, "reset outputs");
		rd_reg(4'h1, 8'h00, "enable reset");
		// random register traffic, enhanced mode toggling
		repeat (30) begin
			lf = lfsr(lf);
			@(posedge clk);
			enh <= lf[9];
			wr_reg(4'h1, lf[7:0]);
			rd_reg(4'h1, ier_m, "enable");
			chk(8'(slp), 8'(ier_m[4]), "sleep");
			wr_reg(4'h2, lf[17:10]);
			@(negedge clk);
			chk(8'(rxl), 8'(rx_exp(lf[17:16])), "rx trigger");
			chk(8'(txl), 8'(enh ? tx_exp(txs_m) : 7'h08), "tx trigger");
			rd_reg(4'h2, {{2{lf[10]}}, 6'h01}, "ident");
		end
		@(posedge clk);
		enh <= 1;
		// each source except tx (bit 1) and sleep (bit 4) masked, then enabled, then withdrawn
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			if (i == 1 || i == 4)
				continue;
			wr_reg(4'h1, ~m);
			step(m, 1'b1, "masked");
			wr_reg(4'h1, m);
			step(m, 1'b0, "raised");
			step(8'h00, 1'b1, "released");
		end
		wr_reg(4'h1, 8'h02);
		step(8'h02, 1'b0, "tx raised");
		@(posedge clk);
		txc <= 1;
		@(posedge clk);
		txc <= 0;
		step(8'h02, 1'b1, "tx cleared");
		wr_reg(4'h1, 8'h00);
		wr_reg(4'h1, 8'h02);
		step(8'h02, 1'b1, "tx re-enabled");
		// host stays off the fifos until both clear strobes have ended
		wr_reg(4'h2, 8'h06);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			chk(8'({txclr, rxclr}), (k < 2) ? 8'h03 : 8'h00, "fifo clear");
		end
		wr_reg(4'h5, 8'hFF);
		rd_reg(4'h1, ier_m, "after stray write");
		rd_reg(4'hF, 8'h00, "unmapped");
		test_done();
	end

	// run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule
